// ==== hdl/dmp_pkg.sv ====
package dmp_pkg;
    // Internal RAM and expansion RAM sizes
    localparam int RAM_BYTES = 256;
    localparam int EXPANSION_RAM_BYTES = 8192;
    localparam int EXPANSION_RAM_AW = 13;

    // Address map of the internal data space and expansion RAM
    localparam logic [7:0] LOW_HALF_TOP = 8'h7F;
    localparam logic [3:0] BIT_BYTE_BASE_HI = 4'h2;
    localparam logic [15:0] EXPANSION_RAM_TOP = 16'h1FFF;

    // Local special registers and their pages
    localparam logic [7:0] SFR_STACK_TOP = 8'h81;
    localparam logic [7:0] SFR_PAGE_CTRL = 8'h84;
    localparam logic [7:0] SFR_STACK_MID = 8'h85;
    localparam logic [7:0] SFR_STACK_BOT = 8'h86;
    localparam logic [7:0] SFR_ACT_PAGE = 8'hA7;
    localparam logic [7:0] SFR_STATUS_WORD = 8'hD0;
    localparam logic [7:0] PAGE_CONFIG = 8'h0F;

    // Reset values
    localparam logic [7:0] STACK_TOP_RST = 8'h07;
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [7:0] STATUS_WORD_RST = 8'h00;
    localparam logic AUTO_PAGE_RST = 1'b1;

    // Status word bank select field
    localparam int BANK_LSB = 3;

    // Pages loaded on interrupt entry
    localparam logic [7:0] IRQ_PAGE_DEFAULT = 8'h00;
    localparam logic [7:0] IRQ_PAGE_CAN = 8'h0C;
    localparam logic [7:0] IRQ_PAGE_HIGH = 8'h10;

    typedef enum logic [3:0] {
        CMD_NONE, CMD_DIR_RD, CMD_DIR_WR, CMD_IND_RD, CMD_IND_WR,
        CMD_BIT_RD, CMD_BIT_WR, CMD_PUSH, CMD_POP,
        CMD_XMOVE_RD, CMD_XMOVE_WR, CMD_CODE_RD
    } dmp_cmd_t;

    typedef enum logic [2:0] {
        SRC_OTHER, SRC_CAN, SRC_SECOND_UART, SRC_COUNTER_ARRAY_ONE,
        SRC_COMPARATOR3, SRC_TIMER45
    } dmp_irq_src_t;

    typedef enum logic [1:0] {PEND_NONE, PEND_SFR, PEND_CODE} dmp_pend_t;

    // Core access request
    typedef struct packed {
        dmp_cmd_t cmd;
        logic ind_sel;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wbit;
    } dmp_req_t;

    // Forwarded special register access
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [7:0] page;
        logic [7:0] wdata;
        logic bit_en;
        logic [2:0] bit_idx;
    } dmp_sfr_t;

    // Flash access through code reads and redirected moves
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } dmp_flash_t;

    typedef struct packed {
        logic [7:0] stack_top_index;
        logic [7:0] program_status_word;
        logic [7:0] active_page_select;
        logic [7:0] page_stack_middle;
        logic [7:0] page_stack_bottom;
        logic bottom_valid;
        logic auto_page_enable;
        logic [7:0] rd_data;
        logic rd_valid;
        logic busy;
        dmp_pend_t pend;
        logic pend_bit;
        logic [2:0] pend_idx;
        dmp_sfr_t special_register;
        dmp_flash_t flash;
    } dmp_state_t;
endpackage

// ==== hdl/dmp_data_space.sv ====
`timescale 1ns/1ps
// Functional notes
// - 256 bytes of internal RAM cover addresses 0x00 to 0xFF.
// - Lower 128 bytes reachable by direct and indirect addressing.
// - Above 0x7F, direct goes to special registers, indirect to upper RAM.
// - 0x00-0x1F form four register banks chosen by status word bits 3, 4.
// - Indirect addresses come from index register zero or one of active bank.
// - Bytes 0x20-0x2F double as 128 bits; bit address is 8*offset plus bit.
// - Bit operand selects single-bit access, byte operand selects byte access.
// - Push writes at stack top plus one, then increments stack top.
// - Reset sets stack top to 0x07, first push lands at 0x08.
// - 8192 bytes of expansion RAM reached through external moves.
// - Code reads read flash; external move reads use expansion RAM, writes expansion RAM or program flash.
// - Direct accesses to 0x80-0xFF go to special registers, not RAM.
// - Special registers at addresses ending 0x0 or 0x8 are bit addressable.
// - Special register space is paged by active page select.
// - All-page registers respond whatever the active page.
// - Interrupt entry pushes page stack and loads the interrupt page.
// - Interrupt return pops page stack; empty bottom supplies 0x00.
// - Software writes to page stack never push or pop it.
// - Entry page is 0x00, 0x0C for CAN, 0x10 for the listed sources.
// - Auto paging enable resets to one; clearing stops page change.
// - Clearing auto paging enable also stops page stack push and pop.
// - Active page select sits at 0xA7 on every page.
module dmp_data_space
    import dmp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Core data-space request
    input wire dmp_pkg::dmp_req_t req,
    output logic busy,
    output logic [7:0] rd_data,
    output logic rd_valid,
    // Interrupt events from the core
    input wire logic irq_entry,
    input wire dmp_pkg::dmp_irq_src_t irq_src,
    input wire logic irq_return,
    // Forwarded special register port
    output dmp_pkg::dmp_sfr_t sfr_out,
    input wire logic [7:0] sfr_rdata,
    // Flash port and move redirection
    input wire logic flash_redirect,
    output dmp_pkg::dmp_flash_t flash_out,
    input wire logic [7:0] flash_rdata,
    // Visible state
    output logic [7:0] stack_top_index,
    output logic [7:0] active_page_select,
    output logic auto_page_enable
);
    import dmp_pkg::*;

    dmp_state_t s;
    dmp_state_t next_s;
    logic [7:0] ram [RAM_BYTES];
    logic [7:0] expansion_ram [EXPANSION_RAM_BYTES];
    logic ram_we;
    logic [7:0] ram_wa;
    logic [7:0] ram_wd;
    logic expansion_ram_we;
    logic [EXPANSION_RAM_AW-1:0] expansion_ram_wa;
    logic [7:0] expansion_ram_wd;
    logic [7:0] index_addr;
    logic [7:0] ind_ptr;
    logic [7:0] bit_byte;
    logic [7:0] loc_val;
    logic loc_hit;
    logic lw_en;
    logic [7:0] lw_addr;
    logic [7:0] lw_val;
    logic [7:0] sfr_byte;
    logic [7:0] sp_inc;

    // Page loaded on interrupt entry
    function automatic logic [7:0] irq_page(input dmp_irq_src_t src);
        case (src)
            SRC_CAN: irq_page = IRQ_PAGE_CAN;
            SRC_SECOND_UART, SRC_COUNTER_ARRAY_ONE, SRC_COMPARATOR3,
            SRC_TIMER45: irq_page = IRQ_PAGE_HIGH;
            default: irq_page = IRQ_PAGE_DEFAULT;
        endcase
    endfunction

    // Address helpers
    assign index_addr = {3'b000, s.program_status_word[BANK_LSB+1:BANK_LSB],
        2'b00, req.ind_sel};
    assign ind_ptr = ram[index_addr];
    assign bit_byte = {BIT_BYTE_BASE_HI, req.addr[6:3]};
    assign sfr_byte = (req.cmd == CMD_BIT_RD || req.cmd == CMD_BIT_WR) ?
        {req.addr[7:3], 3'b000} : req.addr[7:0];
    assign sp_inc = s.stack_top_index + 8'h01;

    // Local special register decode; all-page ones ignore the page
    always_comb begin
        loc_hit = 1'b1;
        loc_val = 8'h00;
        case (sfr_byte)
            SFR_STACK_TOP: loc_val = s.stack_top_index;
            SFR_STATUS_WORD: loc_val = s.program_status_word;
            SFR_ACT_PAGE: loc_val = s.active_page_select;
            SFR_PAGE_CTRL: begin
                loc_hit = (s.active_page_select == PAGE_CONFIG);
                loc_val = {7'h00, s.auto_page_enable};
            end
            SFR_STACK_MID: begin
                loc_hit = (s.active_page_select == PAGE_CONFIG);
                loc_val = s.page_stack_middle;
            end
            SFR_STACK_BOT: begin
                loc_hit = (s.active_page_select == PAGE_CONFIG);
                loc_val = s.page_stack_bottom;
            end
            default: loc_hit = 1'b0;
        endcase
    end

    // Next state: request decode, local writes, then page stack moves
    always_comb begin
        next_s = s;
        next_s.rd_valid = 1'b0;
        next_s.special_register.valid = 1'b0;
        next_s.flash.rd = 1'b0;
        next_s.flash.wr = 1'b0;
        ram_we = 1'b0;
        ram_wa = 8'h00;
        ram_wd = 8'h00;
        expansion_ram_we = 1'b0;
        expansion_ram_wa = '0;
        expansion_ram_wd = 8'h00;
        lw_en = 1'b0;
        lw_addr = sfr_byte;
        lw_val = req.wdata;
        // Finish a forwarded read one cycle after its strobe
        if (s.pend == PEND_SFR) begin
            next_s.rd_valid = 1'b1;
            next_s.rd_data = s.pend_bit ? {7'h00, sfr_rdata[s.pend_idx]} : sfr_rdata;
        end else if (s.pend == PEND_CODE) begin
            next_s.rd_valid = 1'b1;
            next_s.rd_data = flash_rdata;
        end
        next_s.pend = PEND_NONE;
        next_s.pend_bit = 1'b0;
        if (!s.busy) begin
            case (req.cmd)
                CMD_DIR_RD, CMD_DIR_WR: begin
                    if (req.addr[7:0] <= LOW_HALF_TOP) begin
                        if (req.cmd == CMD_DIR_WR) begin
                            ram_we = 1'b1;
                            ram_wa = req.addr[7:0];
                            ram_wd = req.wdata;
                        end else begin
                            next_s.rd_valid = 1'b1;
                            next_s.rd_data = ram[req.addr[7:0]];
                        end
                    end else if (loc_hit) begin
                        if (req.cmd == CMD_DIR_WR) begin
                            lw_en = 1'b1;
                        end else begin
                            next_s.rd_valid = 1'b1;
                            next_s.rd_data = loc_val;
                        end
                    end else begin
                        // Unoccupied addresses forwarded as is
                        next_s.special_register = '{1'b1, req.cmd == CMD_DIR_WR, req.addr[7:0],
                            s.active_page_select, req.wdata, 1'b0, 3'b000};
                        next_s.pend = (req.cmd == CMD_DIR_RD) ? PEND_SFR : PEND_NONE;
                    end
                end
                CMD_IND_RD: begin
                    next_s.rd_valid = 1'b1;
                    next_s.rd_data = ram[ind_ptr];
                end
                CMD_IND_WR: begin
                    ram_we = 1'b1;
                    ram_wa = ind_ptr;
                    ram_wd = req.wdata;
                end
                CMD_BIT_RD, CMD_BIT_WR: begin
                    if (!req.addr[7]) begin
                        // Bit area in RAM, read-modify-write for writes
                        if (req.cmd == CMD_BIT_WR) begin
                            ram_we = 1'b1;
                            ram_wa = bit_byte;
                            ram_wd = ram[bit_byte];
                            ram_wd[req.addr[2:0]] = req.wbit;
                        end else begin
                            next_s.rd_valid = 1'b1;
                            next_s.rd_data = {7'h00, ram[bit_byte][req.addr[2:0]]};
                        end
                    end else if (loc_hit) begin
                        if (req.cmd == CMD_BIT_WR) begin
                            lw_en = 1'b1;
                            lw_val = loc_val;
                            lw_val[req.addr[2:0]] = req.wbit;
                        end else begin
                            next_s.rd_valid = 1'b1;
                            next_s.rd_data = {7'h00, loc_val[req.addr[2:0]]};
                        end
                    end else begin
                        next_s.special_register = '{1'b1, req.cmd == CMD_BIT_WR, sfr_byte,
                            s.active_page_select, {7'h00, req.wbit}, 1'b1,
                            req.addr[2:0]};
                        next_s.pend = (req.cmd == CMD_BIT_RD) ? PEND_SFR : PEND_NONE;
                        next_s.pend_bit = 1'b1;
                        next_s.pend_idx = req.addr[2:0];
                    end
                end
                CMD_PUSH: begin
                    ram_we = 1'b1;
                    ram_wa = sp_inc;
                    ram_wd = req.wdata;
                    next_s.stack_top_index = sp_inc;
                end
                CMD_POP: begin
                    next_s.rd_valid = 1'b1;
                    next_s.rd_data = ram[s.stack_top_index];
                    next_s.stack_top_index = s.stack_top_index - 8'h01;
                end
                CMD_XMOVE_RD: begin
                    next_s.rd_valid = 1'b1;
                    next_s.rd_data = (req.addr <= EXPANSION_RAM_TOP) ?
                        expansion_ram[req.addr[EXPANSION_RAM_AW-1:0]] : 8'h00;
                end
                CMD_XMOVE_WR: begin
                    if (flash_redirect) begin
                        next_s.flash = '{1'b0, 1'b1, req.addr, req.wdata};
                    end else if (req.addr <= EXPANSION_RAM_TOP) begin
                        expansion_ram_we = 1'b1;
                        expansion_ram_wa = req.addr[EXPANSION_RAM_AW-1:0];
                        expansion_ram_wd = req.wdata;
                    end
                end
                CMD_CODE_RD: begin
                    next_s.flash = '{1'b1, 1'b0, req.addr, 8'h00};
                    next_s.pend = PEND_CODE;
                end
                default: ;
            endcase
        end
        next_s.busy = (next_s.pend != PEND_NONE);
        // Local special register writes; stack registers only store
        if (lw_en) begin
            case (lw_addr)
                SFR_STACK_TOP: next_s.stack_top_index = lw_val;
                SFR_STATUS_WORD: next_s.program_status_word = lw_val;
                SFR_ACT_PAGE: next_s.active_page_select = lw_val;
                SFR_PAGE_CTRL: next_s.auto_page_enable = lw_val[0];
                SFR_STACK_MID: next_s.page_stack_middle = lw_val;
                SFR_STACK_BOT: begin
                    next_s.page_stack_bottom = lw_val;
                    next_s.bottom_valid = 1'b1;
                end
                default: ;
            endcase
        end
        // Page stack moves only on interrupt entry or return
        if (s.auto_page_enable) begin
            if (irq_entry) begin
                next_s.page_stack_bottom = s.page_stack_middle;
                next_s.bottom_valid = 1'b1;
                next_s.page_stack_middle = s.active_page_select;
                next_s.active_page_select = irq_page(irq_src);
            end else if (irq_return) begin
                next_s.active_page_select = s.page_stack_middle;
                next_s.page_stack_middle = s.bottom_valid ?
                    s.page_stack_bottom : 8'h00;
                next_s.page_stack_bottom = 8'h00;
                next_s.bottom_valid = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '0;
            s.stack_top_index <= STACK_TOP_RST;
            s.program_status_word <= STATUS_WORD_RST;
            s.active_page_select <= PAGE_RST;
            s.auto_page_enable <= AUTO_PAGE_RST;
            s.pend <= PEND_NONE;
        end else begin
            s <= next_s;
        end
    end

    // Memories carry no reset
    always_ff @(posedge clk) begin
        if (ram_we) begin
            ram[ram_wa] <= ram_wd;
        end
        if (expansion_ram_we) begin
            expansion_ram[expansion_ram_wa] <= expansion_ram_wd;
        end
    end

    // Outputs straight from state
    assign busy = s.busy;
    assign rd_data = s.rd_data;
    assign rd_valid = s.rd_valid;
    assign sfr_out = s.special_register;
    assign flash_out = s.flash;
    assign stack_top_index = s.stack_top_index;
    assign active_page_select = s.active_page_select;
    assign auto_page_enable = s.auto_page_enable;

    // Checks on the design's own behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    chk_push_increment: assert property (
        (req.cmd == CMD_PUSH && !s.busy)
        |=> s.stack_top_index == $past(s.stack_top_index) + 8'h01)
        else $error("push did not advance stack top");

    chk_push_readback: assert property (
        (req.cmd == CMD_PUSH && !s.busy && !irq_entry) ##1
        (req.cmd == CMD_POP && !s.busy)
        |=> rd_valid && rd_data == $past(req.wdata, 2))
        else $error("pop did not return pushed byte");

    chk_irq_push: assert property (
        (irq_entry && s.auto_page_enable)
        |=> s.page_stack_middle == $past(s.active_page_select)
        && s.page_stack_bottom == $past(s.page_stack_middle))
        else $error("page stack push wrong");

    chk_irq_can_page: assert property (
        (irq_entry && s.auto_page_enable && irq_src == SRC_CAN)
        |=> s.active_page_select == IRQ_PAGE_CAN)
        else $error("CAN entry page wrong");

    chk_interrupt_return_instr_pop: assert property (
        (irq_return && !irq_entry && s.auto_page_enable)
        |=> s.active_page_select == $past(s.page_stack_middle)
        && s.bottom_valid == 1'b0)
        else $error("page stack pop wrong");

    chk_auto_off_hold: assert property (
        (!s.auto_page_enable && (irq_entry || irq_return) && req.cmd == CMD_NONE)
        |=> $stable(s.active_page_select) && $stable(s.page_stack_middle))
        else $error("page stack moved while disabled");

    chk_indirect_no_sfr: assert property (
        ((req.cmd == CMD_IND_RD || req.cmd == CMD_IND_WR) && !s.busy)
        |=> !sfr_out.valid)
        else $error("indirect access reached special registers");

    chk_direct_high_fwd: assert property (
        (req.cmd == CMD_DIR_RD && !s.busy && req.addr[7] && !loc_hit)
        |=> sfr_out.valid && !sfr_out.write ##1 rd_valid)
        else $error("direct high read not forwarded");

    chk_bit_sfr_align: assert property (
        (sfr_out.valid && sfr_out.bit_en) |-> sfr_out.addr[2:0] == 3'b000)
        else $error("bit access to non bit-addressable register");
endmodule

// ==== dv/dmp_periph_model.sv ====
`timescale 1ns/1ps
// Peripheral registers and flash on the far side of the block
module dmp_periph_model
    import dmp_pkg::*;
(
    // Clock
    input wire logic clk,
    // Forwarded register port
    input wire dmp_pkg::dmp_sfr_t sfr_out,
    output logic [7:0] sfr_rdata,
    // Flash port
    input wire dmp_pkg::dmp_flash_t flash_out,
    output logic [7:0] flash_rdata,
    // Last accesses seen
    output dmp_pkg::dmp_sfr_t last_sfr,
    output dmp_pkg::dmp_flash_t last_flash
);
    logic [7:0] regs [0:65535];
    logic [7:0] last_rd = 8'h00;
    logic [7:0] last_fl = 8'h00;
    logic [15:0] idx;
    // Data only while asked, else the inverse of the last value
    assign idx = {sfr_out.page, sfr_out.addr};
    assign sfr_rdata = (sfr_out.valid && !sfr_out.write) ? regs[idx] : ~last_rd;
    assign flash_rdata = flash_out.rd ? (flash_out.addr[7:0] ^ 8'h5C) : ~last_fl;
    // Store writes, bit writes change one bit only
    always @(posedge clk) begin
        if (sfr_out.valid) begin
            last_sfr <= sfr_out;
            if (sfr_out.write && sfr_out.bit_en) begin
                regs[idx][sfr_out.bit_idx] <= sfr_out.wdata[0];
            end else if (sfr_out.write) begin
                regs[idx] <= sfr_out.wdata;
            end else begin
                last_rd <= sfr_rdata;
            end
        end
        if (flash_out.rd || flash_out.wr) begin
            last_flash <= flash_out;
        end
        if (flash_out.rd) begin
            last_fl <= flash_rdata;
        end
    end
endmodule

// ==== dv/dmp_data_space_tb.sv ====
`timescale 1ns/1ps
// Self-checking bench for the data space decoder
module dmp_data_space_tb;
    import dmp_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    dmp_req_t req = '0;
    logic irq_entry = 1'b0;
    dmp_irq_src_t irq_src = SRC_OTHER;
    logic irq_return = 1'b0;
    logic flash_redirect = 1'b0;
    logic busy, rd_valid, auto_page_enable;
    logic [7:0] rd_data, sfr_rdata, flash_rdata, stack_top_index, active_page_select;
    dmp_sfr_t sfr_out, last_sfr;
    dmp_flash_t flash_out, last_flash;
    logic [7:0] d;
    int error_cnt = 0;
    int num_checks = 0;
    int cycles = 0;
    dmp_irq_src_t srcs [6] = '{SRC_OTHER, SRC_CAN, SRC_SECOND_UART,
        SRC_COUNTER_ARRAY_ONE, SRC_COMPARATOR3, SRC_TIMER45};
    logic [7:0] pgs [6] = '{8'h00, 8'h0C, 8'h10, 8'h10, 8'h10, 8'h10};

    // Clock
    always #2 clk = ~clk;

    dmp_data_space dmp_data_space_i (
        .clk(clk), .sys_rst(sys_rst), .req(req), .busy(busy), .rd_data(rd_data),
        .rd_valid(rd_valid), .irq_entry(irq_entry), .irq_src(irq_src),
        .irq_return(irq_return), .sfr_out(sfr_out), .sfr_rdata(sfr_rdata),
        .flash_redirect(flash_redirect), .flash_out(flash_out),
        .flash_rdata(flash_rdata), .stack_top_index(stack_top_index),
        .active_page_select(active_page_select), .auto_page_enable(auto_page_enable)
    );

    dmp_periph_model dmp_periph_model_i (
        .clk(clk), .sfr_out(sfr_out), .sfr_rdata(sfr_rdata), .flash_out(flash_out),
        .flash_rdata(flash_rdata), .last_sfr(last_sfr), .last_flash(last_flash)
    );

    // Compare one value
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One request held for one edge
    task automatic xfer(input dmp_cmd_t c, input logic ind, input logic [15:0] a,
                        input logic [7:0] wd, input logic wb);
        @(posedge clk);
        req <= '{cmd: c, ind_sel: ind, addr: a, wdata: wd, wbit: wb};
        @(posedge clk);
        req.cmd <= CMD_NONE;
        #1;
    endtask

    // Direct byte write
    task automatic dwr(input logic [7:0] a, input logic [7:0] v);
        xfer(CMD_DIR_WR, 1'b0, {8'h00, a}, v, 1'b0);
    endtask

    // Read and wait a bounded time for the answer
    task automatic rdx(input dmp_cmd_t c, input logic ind, input logic [15:0] a);
        int n;
        n = 0;
        xfer(c, ind, a, 8'h00, 1'b0);
        while (rd_valid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        d = rd_data;
        if (n == 4) chk("read answer", 16'h0001, 16'h0000);
    endtask

    // Let the far side record the last access
    task automatic settle;
        @(posedge clk);
        #1;
    endtask

    // Interrupt entry or return pulse
    task automatic irq(input logic entry, input dmp_irq_src_t s);
        @(posedge clk);
        irq_entry <= entry;
        irq_return <= !entry;
        irq_src <= s;
        @(posedge clk);
        irq_entry <= 1'b0;
        irq_return <= 1'b0;
        #1;
    endtask

    // Verdict and end of run
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt++;
            end_sim();
        end
    end

    // Test sequence
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk("stack reset", 8'h07, stack_top_index);
        chk("page reset", 8'h00, active_page_select);
        chk("auto reset", 1'b1, auto_page_enable);
        // Index register one of each bank picks the target
        for (int b = 0; b < 4; b++) begin
            dwr(8'(b * 8 + 1), 8'(8'h40 + b));
            dwr(SFR_STATUS_WORD, 8'(b << BANK_LSB));
            xfer(CMD_IND_WR, 1'b1, 16'h0000, 8'(8'h60 + b), 1'b0);
        end
        for (int b = 0; b < 4; b++) begin
            rdx(CMD_DIR_RD, 1'b0, 16'(8'h40 + b));
            chk("bank target", 16'(8'h60 + b), d);
        end
        // Upper half: indirect to RAM, direct to peripheral
        dwr(8'h90, 8'hC3);
        dwr(8'h08, 8'h90);
        dwr(SFR_STATUS_WORD, 8'h08);
        xfer(CMD_IND_WR, 1'b0, 16'h0000, 8'hA5, 1'b0);
        rdx(CMD_IND_RD, 1'b0, 16'h0000);
        chk("upper ram", 8'hA5, d);
        rdx(CMD_DIR_RD, 1'b0, 16'h0090);
        chk("direct high", 8'hC3, d);
        chk("fwd page", 8'h00, last_sfr.page);
        // Bit space of RAM at bit 0x13 and the top end, bit 0x7F
        dwr(8'h22, 8'h00);
        dwr(8'h2F, 8'h00);
        xfer(CMD_BIT_WR, 1'b0, 16'h0013, 8'h00, 1'b1);
        xfer(CMD_BIT_WR, 1'b0, 16'h007F, 8'h00, 1'b1);
        rdx(CMD_DIR_RD, 1'b0, 16'h0022);
        chk("bit 0x13", 8'h08, d);
        rdx(CMD_DIR_RD, 1'b0, 16'h002F);
        chk("bit 0x7F", 8'h80, d);
        rdx(CMD_BIT_RD, 1'b0, 16'h0013);
        chk("bit read", 1'b1, d[0]);
        // Bit and byte access to peripheral registers
        xfer(CMD_BIT_WR, 1'b0, 16'h008B, 8'h00, 1'b1);
        settle();
        chk("sfr bit addr", {8'h88, 4'h1, 1'b1, 3'h3},
            {last_sfr.addr, 3'h0, last_sfr.bit_en, last_sfr.write, last_sfr.bit_idx});
        rdx(CMD_BIT_RD, 1'b0, 16'h008B);
        chk("sfr bit read", 8'h01, d);
        dwr(8'h89, 8'h11);
        settle();
        chk("sfr byte", {8'h89, 8'h11}, {last_sfr.addr, last_sfr.wdata});
        chk("sfr byte en", 1'b0, last_sfr.bit_en);
        // Stack push, pop and wrap
        xfer(CMD_PUSH, 1'b0, 16'h0000, 8'h5A, 1'b0);
        chk("push index", 8'h08, stack_top_index);
        rdx(CMD_DIR_RD, 1'b0, 16'h0008);
        chk("push data", 8'h5A, d);
        rdx(CMD_POP, 1'b0, 16'h0000);
        chk("pop data", 8'h5A, d);
        chk("pop index", 8'h07, stack_top_index);
        dwr(SFR_STACK_TOP, 8'hFF);
        xfer(CMD_PUSH, 1'b0, 16'h0000, 8'h6B, 1'b0);
        chk("wrap index", 8'h00, stack_top_index);
        rdx(CMD_DIR_RD, 1'b0, 16'h0000);
        chk("wrap data", 8'h6B, d);
        // Push then pop on consecutive edges
        @(posedge clk);
        req <= '{cmd: CMD_PUSH, ind_sel: 1'b0, addr: 16'h0000, wdata: 8'h3C, wbit: 1'b0};
        @(posedge clk);
        req.cmd <= CMD_POP;
        @(posedge clk);
        req.cmd <= CMD_NONE;
        #1;
        chk("push pop", {8'h01, 8'h3C}, {7'h00, rd_valid, rd_data});
        // Expansion RAM, its edge, flash redirect and code reads
        xfer(CMD_XMOVE_WR, 1'b0, 16'h1FFF, 8'hE1, 1'b0);
        xfer(CMD_XMOVE_WR, 1'b0, 16'h2000, 8'h12, 1'b0);
        rdx(CMD_XMOVE_RD, 1'b0, 16'h2000);
        chk("expansion_ram outside", 8'h00, d);
        @(posedge clk);
        flash_redirect <= 1'b1;
        xfer(CMD_XMOVE_WR, 1'b0, 16'h1FFF, 8'h9E, 1'b0);
        settle();
        chk("flash write", {1'b1, 16'h1FFF, 8'h9E},
            {last_flash.wr, last_flash.addr, last_flash.wdata});
        flash_redirect <= 1'b0;
        rdx(CMD_XMOVE_RD, 1'b0, 16'h1FFF);
        chk("expansion_ram top", 8'hE1, d);
        xfer(CMD_CODE_RD, 1'b0, 16'h0123, 8'h00, 1'b0);
        chk("code busy", 1'b1, busy);
        chk("code fetch", {1'b1, 16'h0123}, {flash_out.rd, flash_out.addr});
        settle();
        chk("code read", {8'h01, 8'h7F}, {7'h00, rd_valid, rd_data});
        chk("code idle", 1'b0, busy);
        // Page stack over two nested interrupts
        dwr(SFR_ACT_PAGE, 8'h0F);
        chk("page set", 8'h0F, active_page_select);
        irq(1'b1, SRC_CAN);
        chk("entry page", 8'h0C, active_page_select);
        irq(1'b1, SRC_SECOND_UART);
        irq(1'b0, SRC_OTHER);
        chk("pop one", 8'h0C, active_page_select);
        irq(1'b0, SRC_OTHER);
        chk("pop two", 8'h0F, active_page_select);
        rdx(CMD_DIR_RD, 1'b0, {8'h00, SFR_STACK_MID});
        chk("empty bottom", 8'h00, d);
        // Entry page of every source
        for (int i = 0; i < 6; i++) begin
            irq(1'b1, srcs[i]);
            chk("source page", pgs[i], active_page_select);
            irq(1'b0, SRC_OTHER);
            chk("source back", 8'h0F, active_page_select);
        end
        // Software edit of the stack moves nothing
        dwr(SFR_STACK_MID, 8'h0C);
        chk("no move", 8'h0F, active_page_select);
        irq(1'b0, SRC_OTHER);
        chk("edited return", 8'h0C, active_page_select);
        dwr(8'h91, 8'h5D);
        settle();
        chk("fwd page 0C", 8'h0C, last_sfr.page);
        rdx(CMD_DIR_RD, 1'b0, {8'h00, SFR_STACK_TOP});
        chk("all pages", 8'h00, d);
        dwr(SFR_ACT_PAGE, 8'h0F);
        chk("page from 0C", 8'h0F, active_page_select);
        // Auto paging off freezes page and stack
        dwr(SFR_PAGE_CTRL, 8'h00);
        chk("auto off", 1'b0, auto_page_enable);
        irq(1'b1, SRC_CAN);
        chk("no switch", 8'h0F, active_page_select);
        irq(1'b0, SRC_OTHER);
        chk("no pop", 8'h0F, active_page_select);
        rdx(CMD_DIR_RD, 1'b0, {8'h00, SFR_STACK_MID});
        chk("no push", 8'h00, d);
        dwr(SFR_PAGE_CTRL, 8'h01);
        chk("auto on", 1'b1, auto_page_enable);
        end_sim();
    end
endmodule
